//--- pmcg_pkg.sv
`default_nettype none
package pmcg_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int unsigned NUM_CH = 7;
  localparam int unsigned NUM_CARD = 3;
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] NAND_FLASH_CLOCK_CONFIG_OFS = 8'h80;
  localparam logic [ADDR_W-1:0] CARD_PORT0_CLOCK_CONFIG_OFS = 8'h88;
  localparam logic [ADDR_W-1:0] CARD_PORT1_CLOCK_CONFIG_OFS = 8'h8c;
  localparam logic [ADDR_W-1:0] CARD_PORT2_CLOCK_CONFIG_OFS = 8'h90;
  localparam logic [ADDR_W-1:0] CRYPTO_ENGINE_CLOCK_CONFIG_OFS = 8'h9c;
  localparam logic [ADDR_W-1:0] SERIAL_PORT0_CLOCK_CONFIG_OFS = 8'ha0;
  localparam logic [ADDR_W-1:0] SERIAL_PORT1_CLOCK_CONFIG_OFS = 8'ha4;
  localparam logic [ADDR_W-1:0] CLOCK_RUN_STATUS_OFS = 8'ha8;

  // Channel order: nand, card0..2, crypto, serial0..1
  localparam logic [NUM_CH*ADDR_W-1:0] CH_OFS = {
    SERIAL_PORT1_CLOCK_CONFIG_OFS, SERIAL_PORT0_CLOCK_CONFIG_OFS,
    CRYPTO_ENGINE_CLOCK_CONFIG_OFS, CARD_PORT2_CLOCK_CONFIG_OFS,
    CARD_PORT1_CLOCK_CONFIG_OFS, CARD_PORT0_CLOCK_CONFIG_OFS,
    NAND_FLASH_CLOCK_CONFIG_OFS};
  localparam int unsigned CARD_FIRST_CH = 1;
  localparam int unsigned CARD2_CH = 3;

  // ************************************************************
  // Field layout
  // ************************************************************
  localparam int unsigned GATE_BIT = 31;
  localparam int unsigned MODE_BIT = 30;
  localparam int unsigned SRC_LSB = 24;
  localparam int unsigned SPHASE_LSB = 20;
  localparam int unsigned PREDIV_LSB = 16;
  localparam int unsigned OPHASE_LSB = 8;
  localparam int unsigned LDIV_LSB = 0;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_PLAIN = 32'h8303_000f;
  localparam logic [31:0] MASK_CARD = 32'h8373_070f;
  localparam logic [31:0] MASK_CARD2 = 32'hc373_070f;
  localparam logic [1:0] SRC_CRYSTAL = 2'h0;
  localparam logic [1:0] SRC_PLL = 2'h1;

  typedef struct packed {
    logic gate;
    logic card2_mode_select;
    logic [1:0] source_select;
    logic [2:0] sample_phase_delay;
    logic [1:0] pre_div;
    logic [2:0] output_phase_delay;
    logic [3:0] lin_div;
  } pmcg_cfg_type;

  function automatic pmcg_cfg_type pmcg_unpack(input logic [31:0] w);
    pmcg_cfg_type c;
    c.gate = w[GATE_BIT];
    c.card2_mode_select = w[MODE_BIT];
    c.source_select = w[SRC_LSB+:2];
    c.sample_phase_delay = w[SPHASE_LSB+:3];
    c.pre_div = w[PREDIV_LSB+:2];
    c.output_phase_delay = w[OPHASE_LSB+:3];
    c.lin_div = w[LDIV_LSB+:4];
    return c;
  endfunction

endpackage
`default_nettype wire

//--- pmcg_divider.sv
`default_nettype none
module pmcg_divider
  import pmcg_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire pmcg_cfg_type cfg_i,
  input wire logic half_en_i,
  input wire logic crystal_osc_source_i,
  input wire logic peripheral_pll_source_i,
  output logic src_tick_o,
  output logic clk_en_o
);

  logic sel_tick;
  logic [2:0] pre_cnt_r;
  logic [2:0] pre_lim;
  logic [3:0] lin_cnt_r;
  logic pre_tick;
  logic lin_tick;
  logic half_r;
  logic fire;

  // ************************************************************
  // Source selection and dividers
  // ************************************************************
  // Reserved codes pick nothing, so the clock stays quiet
  always_comb
  begin
    case (cfg_i.source_select)
      SRC_CRYSTAL: sel_tick = crystal_osc_source_i;
      SRC_PLL: sel_tick = peripheral_pll_source_i;
      default: sel_tick = 1'b0;
    endcase
  end

  assign pre_lim = 3'((4'h1 << cfg_i.pre_div) - 4'h1);
  assign pre_tick = sel_tick & (pre_cnt_r >= pre_lim);
  assign lin_tick = pre_tick & (lin_cnt_r >= cfg_i.lin_div);
  assign fire = cfg_i.gate & lin_tick & (~half_en_i | half_r);

  // Power-of-two pre-divider; cleared while gated so restart is clean
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      pre_cnt_r <= 3'h0;
    else if (!cfg_i.gate)
      pre_cnt_r <= 3'h0;
    else if (pre_tick)
      pre_cnt_r <= 3'h0;
    else if (sel_tick)
      pre_cnt_r <= pre_cnt_r + 3'h1;
  end

  // Linear divider, m+1 pre-divided ticks per output
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      lin_cnt_r <= 4'h0;
    else if (!cfg_i.gate)
      lin_cnt_r <= 4'h0;
    else if (lin_tick)
      lin_cnt_r <= 4'h0;
    else if (pre_tick)
      lin_cnt_r <= lin_cnt_r + 4'h1;
  end

  // Final halving for the newer card mode
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      half_r <= 1'b0;
    else if (!cfg_i.gate || !half_en_i)
      half_r <= 1'b0;
    else if (lin_tick)
      half_r <= ~half_r;
  end

  // Registered outputs, tick kept aligned with the enable
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      clk_en_o <= 1'b0;
      src_tick_o <= 1'b0;
    end
    else
    begin
      clk_en_o <= fire;
      src_tick_o <= sel_tick & cfg_i.gate;
    end
  end

endmodule // pmcg_divider
`default_nettype wire

//--- pmcg_phase.sv
`default_nettype none
module pmcg_phase
  import pmcg_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic src_tick_i,
  input wire logic pulse_i,
  input wire logic [2:0] delay_i,
  output logic pulse_o
);

  logic [6:0] hist_r;
  logic [7:0] taps;

  // ************************************************************
  // Phase delay in source periods
  // ************************************************************
  // A shift line rather than a counter, so back-to-back pulses at
  // ratio one still each get their own delayed copy
  assign taps = {hist_r, pulse_i};

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      hist_r <= 7'h00;
    else if (src_tick_i)
      hist_r <= taps[6:0];
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      pulse_o <= 1'b0;
    else
      pulse_o <= src_tick_i & taps[delay_i];
  end

endmodule // pmcg_phase
`default_nettype wire

//--- pmcg_top.sv
`default_nettype none
// Behaviour
// - A generator produces its module clock only while its gate bit 31 is one.
// - The module clock is the chosen source divided by the pre-divider then the linear divider.
// - Source code 00 picks the crystal oscillator, 01 the peripheral PLL, 1x is reserved.
// - Pre-divider codes 00, 01, 10, 11 divide by 1, 2, 4, 8.
// - The linear divider field divides by its value plus one, 1 to 16.
// - Each card port delays its sample clock by 0 to 7 source periods.
// - Each card port delays its output clock by 0 to 7 source periods.
// - Bit 30 of the third card port picks legacy mode at 0 and newer mode at 1.
// - Legacy mode adds no further halving to the third card port clock.
// - Newer mode halves the third card port clock after both dividers.
// - Every configuration register resets to zero, clock off, oscillator, ratio one.
module pmcg_top
  import pmcg_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic crystal_osc_source_i,
  input wire logic peripheral_pll_source_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  output logic [NUM_CH-1:0] module_clk_en_o,
  output logic [NUM_CARD-1:0] card_sample_clk_en_o,
  output logic [NUM_CARD-1:0] card_out_clk_en_o
);

  logic [31:0] cfg_r [NUM_CH];
  logic [NUM_CH-1:0] hit;
  logic [NUM_CH-1:0] src_tick;
  logic [NUM_CH-1:0] running;
  logic [31:0] rd_mux;

  // ************************************************************
  // Configuration registers
  // ************************************************************
  generate
    for (genvar ch = 0; ch < NUM_CH; ch++)
    begin : g_ch
      localparam logic [31:0] WMASK = (ch == CARD2_CH) ? MASK_CARD2 :
        ((ch >= CARD_FIRST_CH && ch <= CARD2_CH) ? MASK_CARD : MASK_PLAIN);
      pmcg_cfg_type cfg;
      logic half_en;

      assign hit[ch] = (reg_addr_i == CH_OFS[ch*ADDR_W+:ADDR_W]);
      assign cfg = pmcg_unpack(cfg_r[ch]);
      // Only the third card port has the halving mode
      assign half_en = (ch == CARD2_CH) ? cfg.card2_mode_select : 1'b0;
      assign running[ch] = cfg.gate & ~cfg.source_select[1];

      // Masked write keeps reserved bits at zero
      always_ff @(posedge ref_clk_i or posedge rst_i)
      begin
        if (rst_i)
          cfg_r[ch] <= CFG_RESET;
        else if (reg_we_i && hit[ch])
          cfg_r[ch] <= reg_wdata_i & WMASK;
      end

      pmcg_divider u_div (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .cfg_i(cfg),
        .half_en_i(half_en),
        .crystal_osc_source_i(crystal_osc_source_i),
        .peripheral_pll_source_i(peripheral_pll_source_i),
        .src_tick_o(src_tick[ch]),
        .clk_en_o(module_clk_en_o[ch])
      );

      if (ch >= CARD_FIRST_CH && ch <= CARD2_CH)
      begin : g_card
        pmcg_phase u_sample (
          .ref_clk_i(ref_clk_i),
          .rst_i(rst_i),
          .src_tick_i(src_tick[ch]),
          .pulse_i(module_clk_en_o[ch]),
          .delay_i(cfg.sample_phase_delay),
          .pulse_o(card_sample_clk_en_o[ch-CARD_FIRST_CH])
        );
        pmcg_phase u_output (
          .ref_clk_i(ref_clk_i),
          .rst_i(rst_i),
          .src_tick_i(src_tick[ch]),
          .pulse_i(module_clk_en_o[ch]),
          .delay_i(cfg.output_phase_delay),
          .pulse_o(card_out_clk_en_o[ch-CARD_FIRST_CH])
        );
      end
    end
  endgenerate

  // ************************************************************
  // Read path
  // ************************************************************
  // Unmapped addresses read zero; status shows which clocks run
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (hit[i])
        rd_mux = cfg_r[i];
    end
    if (reg_addr_i == CLOCK_RUN_STATUS_OFS)
      rd_mux = {{(32-NUM_CH){1'b0}}, running};
  end

  // Read data stand for the one cycle after the strobe only
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      reg_rdata_o <= 32'h0000_0000;
    else if (reg_re_i)
      reg_rdata_o <= rd_mux;
    else
      reg_rdata_o <= 32'h0000_0000;
  end

endmodule // pmcg_top
`default_nettype wire

//--- pmcg_top_monitor.sv
`default_nettype none
// ****************
// Port checks
// ****************
module pmcg_top_monitor
  import pmcg_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic crystal_osc_source_i,
  input wire logic peripheral_pll_source_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic [NUM_CH-1:0] module_clk_en_o,
  input wire logic [NUM_CARD-1:0] card_sample_clk_en_o,
  input wire logic [NUM_CARD-1:0] card_out_clk_en_o
);
  // Any source tick, either source
  wire logic src_w;
  assign src_w = crystal_osc_source_i | peripheral_pll_source_i;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  property p_idle; !reg_re_i |=> reg_rdata_o == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data not zero");
  property p_unmap; reg_re_i && reg_addr_i == 8'h84 |=> reg_rdata_o == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_mask;
    reg_we_i && reg_addr_i == 8'h80 ##1 reg_re_i && reg_addr_i == 8'h80
      |=> reg_rdata_o == ($past(reg_wdata_i, 2) & MASK_PLAIN);
  endproperty
  a_mask: assert property (p_mask) else $error("plain mask");
  property p_mask2;
    reg_we_i && reg_addr_i == 8'h90 ##1 reg_re_i && reg_addr_i == 8'h90
      |=> reg_rdata_o == ($past(reg_wdata_i, 2) & MASK_CARD2);
  endproperty
  a_mask2: assert property (p_mask2) else $error("card2 mask");
  // Pulse launched before the write may still land one cycle later
  property p_gate;
    reg_we_i && reg_addr_i == 8'h80 && !reg_wdata_i[31] |-> ##2 !module_clk_en_o[0];
  endproperty
  a_gate: assert property (p_gate) else $error("clock after gate off");
  property p_src; module_clk_en_o[0] |-> $past(src_w); endproperty
  a_src: assert property (p_src) else $error("pulse without source");
  // Phase pulses sit two registers behind the source tick
  property p_samp; card_sample_clk_en_o[0] |-> $past(src_w, 2); endproperty
  a_samp: assert property (p_samp) else $error("sample pulse off tick");
  property p_out; card_out_clk_en_o[2] |-> $past(src_w, 2); endproperty
  a_out: assert property (p_out) else $error("output pulse off tick");
endmodule // pmcg_top_monitor

bind pmcg_top pmcg_top_monitor u_mon (.ref_clk_i, .rst_i, .crystal_osc_source_i,
  .peripheral_pll_source_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i,
  .reg_rdata_o, .module_clk_en_o, .card_sample_clk_en_o, .card_out_clk_en_o);
`default_nettype wire

//--- tb.sv
`default_nettype none
module tb
  import pmcg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 0, rst_i = 1, xo = 0, pll = 0, we = 0, re = 0, src_on = 0;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [6:0] mclk;
  logic [2:0] sclk, oclk;
  int fails = 0, checked = 0, cyc = 0, gcnt = 0;
  int mcnt[7] = '{default: 0};

  pmcg_top uut (.ref_clk_i, .rst_i, .crystal_osc_source_i(xo),
    .peripheral_pll_source_i(pll), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .module_clk_en_o(mclk),
    .card_sample_clk_en_o(sclk), .card_out_clk_en_o(oclk));

  initial forever #5 ref_clk_i = ~ref_clk_i;

  // ****************
  // Sources, pulse counts, timeout
  // ****************
  // Rates 1/3 and 1/2 differ, so a wrong source select shows in the counts
  always @(posedge ref_clk_i)
  begin
    gcnt <= src_on ? gcnt + 1 : 0;
    xo <= src_on && gcnt % 3 == 0;
    pll <= src_on && gcnt % 2 == 0;
    for (int i = 0; i < 7; i++) mcnt[i] <= mcnt[i] + mclk[i];
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (fails == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // ****************
  // Register bus
  // ****************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk_i);
    we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk_i);
    re <= 1'b1;
    addr <= a;
    @(posedge ref_clk_i);
    re <= 1'b0;
    #1 check(rdata, exp);
  endtask

  // Write then read with no gap
  task automatic wrd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
    wr(a, d);
    re <= 1'b1;
    @(posedge ref_clk_i);
    re <= 1'b0;
    #1 check(rdata, exp);
  endtask

  // Gate off clears the divider, then s ticks of the chosen source
  task automatic run(input int ch, input logic [31:0] cfg, input int s, input int exp);
    int base;
    wr(CH_OFS[ch*8+:8], 32'h0);
    wr(CH_OFS[ch*8+:8], cfg);
    // Baseline, so the counters keep a single writer
    #1 base = mcnt[ch];
    @(posedge ref_clk_i);
    src_on <= 1'b1;
    repeat (s * (cfg[24] ? 2 : 3)) @(posedge ref_clk_i);
    src_on <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    #1 check(mcnt[ch] - base, exp);
  endtask

  // Cycles from module pulse to sample and output pulses, ratio 8 on the PLL
  task automatic phase(input int c, input int sd, input int od);
    int w, ks, ko;
    w = 0;
    ks = -1;
    ko = -1;
    wr(CH_OFS[(c+1)*8+:8], 32'h0);
    wr(CH_OFS[(c+1)*8+:8], 32'h8103_0000 | sd << 20 | od << 8);
    src_on <= 1'b1;
    while (mclk[c+1] !== 1'b1 && w < 100)
    begin
      @(posedge ref_clk_i);
      #1 w++;
    end
    for (int k = 0; k < 16; k++)
    begin
      if (sclk[c] === 1'b1 && ks < 0) ks = k;
      if (oclk[c] === 1'b1 && ko < 0) ko = k;
      @(posedge ref_clk_i);
      #1;
    end
    src_on <= 1'b0;
    // One registered stage after the tick that ends the delay
    check(ks, sd * 2 + 1);
    check(ko, od * 2 + 1);
  endtask

  // ****************
  // Tests
  // ****************
  initial
  begin
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) rd(i < 7 ? CH_OFS[i*8+:8] : CLOCK_RUN_STATUS_OFS, 32'h0);
    for (int i = 0; i < 7; i++)
      wrd(CH_OFS[i*8+:8], '1,
        i == 3 ? MASK_CARD2 : (i > 0 && i < 3) ? MASK_CARD : MASK_PLAIN);
    wrd(8'h84, '1, 32'h0);
    rd(CLOCK_RUN_STATUS_OFS, 32'h0);
    run(0, 32'h8300_0000, 4, 0);
    run(1, 32'h0100_0000, 4, 0);
    // Every source, pre-divider code and the linear extremes 1 and 16
    for (int i = 0; i < 7; i++)
      run(i, 32'h8000_0000 | (i % 2) << 24 | (i % 4) << 16 | (i * 5) % 16,
        2 * (1 << (i % 4)) * ((i * 5) % 16 + 1), 2);
    rd(CLOCK_RUN_STATUS_OFS, 32'h7f);
    run(3, 32'hc100_0002, 12, 2);
    phase(0, 0, 7);
    phase(1, 7, 0);
    phase(2, 3, 5);
    end_sim();
  end
endmodule // tb
`default_nettype wire
